/* logic/gfiop_ext_irq.sv */
// sticky edge detector for one external interrupt pin
// assumes the pin level is already synchronous to clk_sys
`timescale 1ns/1ps
module gfiop_ext_irq (
	input wire logic     clk_sys,
	input wire logic     arst_n,
	gfiop_irq_if.det     irq
);
	logic prev_ff;
	logic primed_ff;
	logic status_ff;
	wire  rise_w = irq.level & ~prev_ff;
	wire  fall_w = ~irq.level & prev_ff;
	wire  hit_w  = irq.enable & primed_ff &
		((irq.edge_mode == gfiop_pkg::EDGE_RISE) ? rise_w :
		 (irq.edge_mode == gfiop_pkg::EDGE_FALL) ? fall_w :
		 (rise_w | fall_w));
	// first cycle after reset only loads the level, so no false edge
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prev_ff   <= 1'b0;
			primed_ff <= 1'b0;
			status_ff <= 1'b0;
		end
		else
		begin
			prev_ff   <= irq.level;
			primed_ff <= 1'b1;
			// set beats a same-cycle clear
			status_ff <= hit_w | (status_ff & ~irq.clear);
		end
	end
	assign irq.status = status_ff;

	edge_sets_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		hit_w |=> status_ff)
		else $error("edge did not set interrupt status");
	clear_holds_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(status_ff && !irq.clear) |=> status_ff)
		else $error("interrupt status dropped without clear");
endmodule : gfiop_ext_irq

/* logic/gfiop_port.sv */
// pin two function mux, drive and pull-up setup, and the shared io port
// register; pins zero and one are set up elsewhere, only their select
// codes and levels come in here; all inputs synchronous to clk_sys
`timescale 1ns/1ps
module gfiop_port (
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic [4:0] pin_zero_function_select,
	input  wire logic [4:0] pin_one_function_select,
	input  wire logic       pin_zero_level,
	input  wire logic       pin_one_level,
	output logic            direct_io_pin_zero,
	output logic            direct_io_pin_one,
	input  wire logic       pin_two_i,
	output logic            pin_two_o,
	output logic            pin_two_oe,
	output logic            pin_two_pullup_enable,
	output logic      [1:0] pin_two_drive_strength,
	output logic            pin_two_adc_route,
	output logic            pin_two_vref_out,
	output logic            tx_mod_data,
	output logic            retx_request,
	input  wire logic       mcu_clk,
	input  wire logic       wake_up_timer,
	input  wire logic       low_battery,
	input  wire logic       data_clk,
	input  wire logic       rx_data,
	input  wire logic       tx_state,
	input  wire logic       rx_state,
	input  wire logic       tx_fifo_afull,
	input  wire logic       rx_fifo_afull,
	input  wire logic       antenna_one,
	input  wire logic       antenna_two,
	input  wire logic       preamble_valid,
	input  wire logic       preamble_invalid,
	input  wire logic       sync_detected,
	input  wire logic       clear_channel,
	input  wire logic       interrupt_request_n,
	input  wire logic       chip_select_n,
	input  wire logic       spi_data_out,
	output logic            serial_data_out
);
	logic [7:0] pin_two_config_ff;
	logic [7:0] io_port_config_ff;
	logic [7:0] rdata_ff;
	logic       pin_o_ff;
	logic       pin_oe_ff;
	logic       pup_ff;
	logic       adc_ff;
	logic       vref_ff;
	logic       txd_ff;
	logic       retx_ff;
	logic       nxt_pin_o;
	logic       nxt_pin_oe;
	logic [7:0] nxt_rdata;

	gfiop_irq_if irq_if [3] ();

	// register decode
	wire        wr_two_w  = reg_wr & (reg_addr == gfiop_pkg::OFS_PIN_TWO);
	wire        wr_port_w = reg_wr & (reg_addr == gfiop_pkg::OFS_IO_PORT);
	wire        rd_two_w  = reg_rd & (reg_addr == gfiop_pkg::OFS_PIN_TWO);
	wire        rd_port_w = reg_rd & (reg_addr == gfiop_pkg::OFS_IO_PORT);

	wire [4:0]  sel_w = pin_two_config_ff[gfiop_pkg::SEL_HI:0];
	wire [4:0]  sel_pin [3];
	wire [2:0]  lvl_pin;
	assign sel_pin[0] = pin_zero_function_select;
	assign sel_pin[1] = pin_one_function_select;
	assign sel_pin[2] = sel_w;
	assign lvl_pin    = {pin_two_i, pin_one_level, pin_zero_level};

	// digital input kinds that take the pull-up
	wire        dig_in_w = (sel_w == gfiop_pkg::FN_DIN) ||
		(sel_w == gfiop_pkg::FN_IRQ_FALL) ||
		(sel_w == gfiop_pkg::FN_IRQ_RISE) ||
		(sel_w == gfiop_pkg::FN_IRQ_ANY) ||
		(sel_w == gfiop_pkg::FN_TX_DATA) ||
		(sel_w == gfiop_pkg::FN_RETX_REQ);
	wire        analog_w = (sel_w == gfiop_pkg::FN_ADC_IN) ||
		(sel_w == gfiop_pkg::FN_TEST_IN_N) ||
		(sel_w == gfiop_pkg::FN_TEST_IN_P) ||
		(sel_w == gfiop_pkg::FN_VREF);
	wire        nxt_pup = pin_two_config_ff[gfiop_pkg::PUP_BIT] &
		dig_in_w;

	// per-pin direct input and interrupt setup
	wire [2:0]  din_w;
	wire [2:0]  stat_w;
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_pin
			assign din_w[g] = (sel_pin[g] == gfiop_pkg::FN_DIN);
			assign irq_if[g].enable =
				(sel_pin[g] == gfiop_pkg::FN_IRQ_FALL) ||
				(sel_pin[g] == gfiop_pkg::FN_IRQ_RISE) ||
				(sel_pin[g] == gfiop_pkg::FN_IRQ_ANY);
			assign irq_if[g].edge_mode =
				(sel_pin[g] == gfiop_pkg::FN_IRQ_FALL) ?
				gfiop_pkg::EDGE_FALL :
				(sel_pin[g] == gfiop_pkg::FN_IRQ_RISE) ?
				gfiop_pkg::EDGE_RISE : gfiop_pkg::EDGE_ANY;
			assign irq_if[g].level = lvl_pin[g];
			// reading the port register acknowledges the status
			assign irq_if[g].clear = rd_port_w;
			assign stat_w[g] = irq_if[g].status;
			gfiop_ext_irq u_irq (
				.clk_sys (clk_sys),
				.arst_n  (arst_n),
				.irq     (irq_if[g])
			);
		end
	endgenerate

	// direct io bits read the pin when it is a direct input
	wire [2:0]  dio_rd_w = (lvl_pin & din_w) |
		(io_port_config_ff[gfiop_pkg::DIO_HI:gfiop_pkg::DIO_LO] &
		 ~din_w);
	wire [7:0]  port_rd_w = {1'b0, stat_w,
		io_port_config_ff[gfiop_pkg::ITSDO_BIT], dio_rd_w};

	assign nxt_rdata = rd_two_w ? pin_two_config_ff :
		rd_port_w ? port_rd_w : 8'h00;

	// pin two output mux
	always_comb
	begin
		nxt_pin_oe = ~(dig_in_w | analog_w);
		nxt_pin_o  = 1'b0;
		case (sel_w)
			gfiop_pkg::FN_MCU_CLK:   nxt_pin_o = mcu_clk;
			gfiop_pkg::FN_WAKE_TMR:  nxt_pin_o = wake_up_timer;
			gfiop_pkg::FN_LOW_BATT:  nxt_pin_o = low_battery;
			gfiop_pkg::FN_DOUT:      nxt_pin_o =
				io_port_config_ff[gfiop_pkg::DIO_HI];
			gfiop_pkg::FN_DATA_CLK:  nxt_pin_o = data_clk;
			gfiop_pkg::FN_RX_DATA:   nxt_pin_o = rx_data;
			gfiop_pkg::FN_TX_STATE:  nxt_pin_o = tx_state;
			gfiop_pkg::FN_RX_STATE:  nxt_pin_o = rx_state;
			gfiop_pkg::FN_TX_AFULL:  nxt_pin_o = tx_fifo_afull;
			gfiop_pkg::FN_RX_AFULL:  nxt_pin_o = rx_fifo_afull;
			gfiop_pkg::FN_ANT1:      nxt_pin_o = antenna_one;
			gfiop_pkg::FN_ANT2:      nxt_pin_o = antenna_two;
			gfiop_pkg::FN_PRE_VALID: nxt_pin_o = preamble_valid;
			gfiop_pkg::FN_PRE_INVAL: nxt_pin_o = preamble_invalid;
			gfiop_pkg::FN_SYNC:      nxt_pin_o = sync_detected;
			gfiop_pkg::FN_CCA:       nxt_pin_o = clear_channel;
			gfiop_pkg::FN_VDD:       nxt_pin_o = 1'b1;
			default:                 nxt_pin_o = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			pin_two_config_ff <= gfiop_pkg::RST_PIN_TWO;
		else if (wr_two_w)
			pin_two_config_ff <= reg_wdata;
	end

	// status and reserved bits are not stored
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			io_port_config_ff <= gfiop_pkg::RST_IO_PORT;
		else if (wr_port_w)
			io_port_config_ff <= reg_wdata & 8'h0f;
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			rdata_ff <= 8'h00;
		else
			rdata_ff <= nxt_rdata;
	end

	// pin two o, oe, pull-up, adc, vref and the tx, retx outputs are registered: one clk_sys of latency behind the sources
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pin_o_ff  <= 1'b0;
			pin_oe_ff <= 1'b0;
			pup_ff    <= 1'b0;
			adc_ff    <= 1'b0;
			vref_ff   <= 1'b0;
			txd_ff    <= 1'b0;
			retx_ff   <= 1'b0;
		end
		else
		begin
			pin_o_ff  <= nxt_pin_o;
			pin_oe_ff <= nxt_pin_oe;
			pup_ff    <= nxt_pup;
			adc_ff    <= (sel_w == gfiop_pkg::FN_ADC_IN);
			vref_ff   <= (sel_w == gfiop_pkg::FN_VREF);
			txd_ff    <= (sel_w == gfiop_pkg::FN_TX_DATA) &
				pin_two_i;
			retx_ff   <= (sel_w == gfiop_pkg::FN_RETX_REQ) &
				pin_two_i;
		end
	end

	assign reg_rdata              = rdata_ff;
	assign pin_two_o              = pin_o_ff;
	assign pin_two_oe             = pin_oe_ff;
	assign pin_two_pullup_enable  = pup_ff;
	assign pin_two_drive_strength =
		pin_two_config_ff[gfiop_pkg::DRV_HI:gfiop_pkg::DRV_LO];
	assign pin_two_adc_route      = adc_ff;
	assign pin_two_vref_out       = vref_ff;
	assign tx_mod_data            = txd_ff;
	assign retx_request           = retx_ff;
	assign direct_io_pin_zero     = io_port_config_ff[0];
	assign direct_io_pin_one      = io_port_config_ff[1];
	// kept combinational: serial out must follow the spi shift timing
	assign serial_data_out =
		(io_port_config_ff[gfiop_pkg::ITSDO_BIT] & chip_select_n) ?
		interrupt_request_n : spi_data_out;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	sequence s_cfg_write;
		wr_two_w;
	endsequence
	sequence s_port_read;
		rd_port_w;
	endsequence

	pullup_follow_a: assert property (
		(wr_two_w && reg_wdata[5] && reg_wdata[4:0] == 5'h03)
		|=> ##1 pin_two_pullup_enable)
		else $error("pull-up not enabled for digital input");
	cfg_readback_a: assert property (
		s_cfg_write ##1 !wr_two_w ##1 rd_two_w |=>
		reg_rdata == $past(reg_wdata, 3))
		else $error("config register readback wrong");
	wut_output_a: assert property (
		(sel_w == 5'h01 && !wr_two_w) |=>
		(pin_two_o == $past(wake_up_timer) && pin_two_oe))
		else $error("wake-up timer not on pin two");
	dout_drive_a: assert property (
		(sel_w == 5'h0a && !wr_two_w) |=>
		(pin_two_o == $past(io_port_config_ff[2]) && pin_two_oe))
		else $error("direct output does not follow bit");
	vdd_drive_a: assert property (
		(sel_w == 5'h1d && !wr_two_w) |=> (pin_two_o && pin_two_oe))
		else $error("pin two not driven high");
	sdo_irq_a: assert property (
		(io_port_config_ff[3] && chip_select_n) |->
		serial_data_out == interrupt_request_n)
		else $error("interrupt request missing on sdo");
	din_read_a: assert property (
		(s_port_read and sel_w == 5'h03) |=>
		reg_rdata[2] == $past(pin_two_i))
		else $error("direct input level not read back");
	rsv_zero_a: assert property (
		s_port_read |=> reg_rdata[7] == 1'b0)
		else $error("reserved port bit not zero");
	stat_read_a: assert property (
		(s_port_read and stat_w[2]) |=> reg_rdata[6])
		else $error("pin two interrupt status not read");
endmodule : gfiop_port

/* shared/gfiop_irq_if.sv */
// carries one pin's interrupt setup and status between port and detector
// assumes all signals live on clk_sys
`timescale 1ns/1ps
interface gfiop_irq_if;
	logic [1:0] edge_mode;
	logic       enable;
	logic       level;
	logic       clear;
	logic       status;
	modport det (input edge_mode, input enable, input level,
		input clear, output status);
	modport ctl (output edge_mode, output enable, output level,
		output clear, input status);
endinterface : gfiop_irq_if

/* shared/gfiop_pkg.sv */
// constants for the pin two function mux and the shared io port register
// assumes an 8-bit register port with one-cycle read latency
// Functional notes
// - pin two pull-up is on when its enable bit is set and the pin is a digital input.
// - pin two function comes from bits 4:0 of its config register.
// - codes 0,1,2 output the mcu clock, wake-up timer expiry and low battery.
// - code 3 is a direct digital input and code 10 a direct digital output.
// - codes 4,5,6 are external interrupt inputs on falling, rising, any edge.
// - code 7 routes the pin to the adc, code 14 outputs vref, 8 and 9 are test inputs.
// - code 15 outputs data clock, 16 takes modulation data, 20 outputs rx data.
// - code 17 takes a retransmission request from outside.
// - codes 18,21 give tx and rx state, 19,22 the fifo almost-full flags.
// - codes 23,24 drive the two antenna switch controls.
// - codes 25 to 28 give preamble, sync and channel flags, 29 high, others low.
// - bits 7:6 of the config register hold a readable drive strength.
// - bits 6,5,4 of the port register report interrupt status of pins 2,1,0.
// - with bit 3 set and chip select high, the irq goes to serial out.
// - a pin set as direct output drives the value of its direct io bit.
// - a pin set as direct input reads its level through its direct io bit.
package gfiop_pkg;
	localparam int         ADDR_W        = 8;
	localparam int         DATA_W        = 8;
	localparam logic [7:0] OFS_PIN_TWO   = 8'h0d;
	localparam logic [7:0] OFS_IO_PORT   = 8'h0e;
	localparam logic [7:0] RST_PIN_TWO   = 8'h00;
	localparam logic [7:0] RST_IO_PORT   = 8'h00;
	localparam int         DRV_HI        = 7;
	localparam int         DRV_LO        = 6;
	localparam int         PUP_BIT       = 5;
	localparam int         SEL_HI        = 4;
	localparam int         RSV_BIT       = 7;
	localparam int         STAT_HI       = 6;
	localparam int         STAT_LO       = 4;
	localparam int         ITSDO_BIT     = 3;
	localparam int         DIO_HI        = 2;
	localparam int         DIO_LO        = 0;
	localparam logic [4:0] FN_MCU_CLK    = 5'h00;
	localparam logic [4:0] FN_WAKE_TMR   = 5'h01;
	localparam logic [4:0] FN_LOW_BATT   = 5'h02;
	localparam logic [4:0] FN_DIN        = 5'h03;
	localparam logic [4:0] FN_IRQ_FALL   = 5'h04;
	localparam logic [4:0] FN_IRQ_RISE   = 5'h05;
	localparam logic [4:0] FN_IRQ_ANY    = 5'h06;
	localparam logic [4:0] FN_ADC_IN     = 5'h07;
	localparam logic [4:0] FN_TEST_IN_N  = 5'h08;
	localparam logic [4:0] FN_TEST_IN_P  = 5'h09;
	localparam logic [4:0] FN_DOUT       = 5'h0a;
	localparam logic [4:0] FN_VREF       = 5'h0e;
	localparam logic [4:0] FN_DATA_CLK   = 5'h0f;
	localparam logic [4:0] FN_TX_DATA    = 5'h10;
	localparam logic [4:0] FN_RETX_REQ   = 5'h11;
	localparam logic [4:0] FN_TX_STATE   = 5'h12;
	localparam logic [4:0] FN_TX_AFULL   = 5'h13;
	localparam logic [4:0] FN_RX_DATA    = 5'h14;
	localparam logic [4:0] FN_RX_STATE   = 5'h15;
	localparam logic [4:0] FN_RX_AFULL   = 5'h16;
	localparam logic [4:0] FN_ANT1       = 5'h17;
	localparam logic [4:0] FN_ANT2       = 5'h18;
	localparam logic [4:0] FN_PRE_VALID  = 5'h19;
	localparam logic [4:0] FN_PRE_INVAL  = 5'h1a;
	localparam logic [4:0] FN_SYNC       = 5'h1b;
	localparam logic [4:0] FN_CCA        = 5'h1c;
	localparam logic [4:0] FN_VDD        = 5'h1d;
	localparam logic [1:0] EDGE_FALL     = 2'h0;
	localparam logic [1:0] EDGE_RISE     = 2'h1;
	localparam logic [1:0] EDGE_ANY      = 2'h2;
endpackage : gfiop_pkg

/* verification/gfiop_pin_model.sv */
// outside circuit on pin two: a driver, the pull-up and a bare net
// assumes pin outputs registered on clk_sys; ext_v only counts when ext_en
`timescale 1ns/1ps
module gfiop_pin_model (
	input  wire logic clk_sys,
	input  wire logic pin_o,
	input  wire logic pin_oe,
	input  wire logic pullup_en,
	input  wire logic ext_en,
	input  wire logic ext_v,
	output logic      pin_level
);
	logic float_ff = 1'b0;

	// a bare net toggles so that a stale level never reads as valid
	always @(posedge clk_sys)
	begin
		float_ff <= ~float_ff;
	end

	assign pin_level = pin_oe ? pin_o : ext_en ? ext_v :
		pullup_en ? 1'b1 : float_ff;
endmodule : gfiop_pin_model

/* verification/tb_top.sv */
// self-checking bench for the pin two mux and the shared io port register
// assumes gfiop_port and gfiop_pin_model; reads checked through a queue
`timescale 1ns/1ps
module tb_top;
	logic        clk_sys = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic [4:0]  fs0 = 5'h00;
	logic [4:0]  fs1 = 5'h00;
	logic        lv0 = 1'b0, lv1 = 1'b0, dio_zero, dio_one;
	logic        pin_i, pin_o, pin_oe;
	logic        pup, adc, vref, txm, retx, ser_out;
	logic [1:0]  drv;
	logic [28:0] src = 29'h0;
	logic        irq_n = 1'b1, cs_n = 1'b1, spi_do = 1'b0;
	logic        ext_en = 1'b1, ext_v = 1'b1, rd_q = 1'b0;
	logic [7:0]  exp_q[$];
	int          fails = 0, check_count = 0;

	always #50 clk_sys = ~clk_sys;

	gfiop_port i_gfiop_port (.clk_sys(clk_sys), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pin_zero_function_select(fs0), .pin_one_function_select(fs1),
		.pin_zero_level(lv0), .pin_one_level(lv1),
		.direct_io_pin_zero(dio_zero), .direct_io_pin_one(dio_one),
		.pin_two_i(pin_i), .pin_two_o(pin_o), .pin_two_oe(pin_oe),
		.pin_two_pullup_enable(pup), .pin_two_drive_strength(drv),
		.pin_two_adc_route(adc), .pin_two_vref_out(vref),
		.tx_mod_data(txm), .retx_request(retx), .mcu_clk(src[0]),
		.wake_up_timer(src[1]), .low_battery(src[2]), .data_clk(src[15]),
		.rx_data(src[20]), .tx_state(src[18]), .rx_state(src[21]),
		.tx_fifo_afull(src[19]), .rx_fifo_afull(src[22]),
		.antenna_one(src[23]), .antenna_two(src[24]),
		.preamble_valid(src[25]), .preamble_invalid(src[26]),
		.sync_detected(src[27]), .clear_channel(src[28]),
		.interrupt_request_n(irq_n), .chip_select_n(cs_n),
		.spi_data_out(spi_do), .serial_data_out(ser_out));

	gfiop_pin_model i_gfiop_pin_model (.clk_sys(clk_sys), .pin_o(pin_o),
		.pin_oe(pin_oe), .pullup_en(pup), .ext_en(ext_en), .ext_v(ext_v),
		.pin_level(pin_i));

	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test

	task automatic compare(input string what, input logic [7:0] e,
		input logic [7:0] g);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask : compare

	task automatic compare_bit(input string what, input logic e,
		input logic g);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %s expected %b seen %b", what, e, g);
		end
	endtask : compare_bit

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
	endtask : rd

	// ends just past an edge so registered outputs have landed
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : settle

	// expected {oe, o} of pin two for a function code
	function automatic logic [1:0] exp_pin(input logic [4:0] c,
		input logic [28:0] s);
		if (c inside {[5'h03:5'h09], 5'h0e, 5'h10, 5'h11})
			return 2'b00;
		if (c == 5'h1d)
			return 2'b11;
		if (c inside {[5'h00:5'h02], 5'h0f, [5'h12:5'h1c]})
			return {1'b1, s[c]};
		return 2'b10;
	endfunction : exp_pin

	always @(posedge clk_sys)
	begin
		if (rd_q)
			compare("reg_rdata", exp_q.pop_front(), reg_rdata);
		rd_q <= reg_rd;
	end

	// the whole run is well under 2000 cycles
	initial
	begin : watchdog
		#(200_000);
		fails++;
		stop_test();
	end

	initial
	begin : main
		logic [7:0] cfg;
		logic [4:0] c;
		logic [1:0] eo;
		void'($urandom(59));
		repeat (12) @(posedge clk_sys);
		arst_n <= 1'b1;
		rd(8'h0d, 8'h00);
		rd(8'h0e, 8'h00);
		rd(8'h20, 8'h00);
		for (int k = 0; k < 32; k++)
		begin
			c = k[4:0];
			cfg = {2'($urandom), 1'($urandom), c};
			src <= 29'($urandom);
			ext_v <= (c inside {5'h10, 5'h11}) ? 1'($urandom) : 1'b1;
			wr(8'h0d, cfg);
			rd(8'h0d, cfg);
			settle(3);
			eo = exp_pin(c, src);
			compare_bit("pin_two_oe", eo[1], pin_oe);
			if (eo[1])
				compare_bit("pin_two_o", eo[0], pin_o);
			compare_bit("pullup", cfg[5] &&
				c inside {[5'h03:5'h06], 5'h10, 5'h11}, pup);
			compare("drive", {6'h00, cfg[7:6]}, {6'h00, drv});
			compare_bit("adc", c == 5'h07, adc);
			compare_bit("vref", c == 5'h0e, vref);
			compare_bit("tx_mod", c == 5'h10 && ext_v, txm);
			compare_bit("retx", c == 5'h11 && ext_v, retx);
		end
		fs0 <= 5'h0a;
		fs1 <= 5'h0a;
		wr(8'h0e, 8'hfe);
		rd(8'h0e, 8'h0e);
		wr(8'h0d, 8'h0a);
		settle(2);
		compare_bit("pin_two_o", 1'b1, pin_o);
		compare_bit("dio_zero", 1'b0, dio_zero);
		compare_bit("dio_one", 1'b1, dio_one);
		wr(8'h0e, 8'h0b);
		settle(2);
		compare_bit("pin_two_o", 1'b0, pin_o);
		compare_bit("dio_zero", 1'b1, dio_zero);
		@(posedge clk_sys);
		fs0 <= 5'h03;
		fs1 <= 5'h03;
		wr(8'h0d, 8'h03);
		for (int v = 0; v < 2; v++)
		begin
			@(posedge clk_sys);
			ext_v <= v[0];
			lv0 <= 1'($urandom);
			lv1 <= 1'($urandom);
			settle(3);
			rd(8'h0e, {5'h01, v[0], lv1, lv0});
		end
		// undriven pin two with its pull-up on must read high
		ext_en <= 1'b0;
		wr(8'h0d, 8'h23);
		settle(3);
		rd(8'h0e, {5'h01, 1'b1, lv1, lv0});
		// levels settle a cycle before the pins become interrupt inputs
		@(posedge clk_sys);
		ext_en <= 1'b1;
		ext_v <= 1'b0;
		lv0 <= 1'b1;
		lv1 <= 1'b0;
		@(posedge clk_sys);
		fs0 <= 5'h04;
		fs1 <= 5'h06;
		wr(8'h0d, 8'h05);
		settle(3);
		rd(8'h0e, 8'h0b);
		@(posedge clk_sys);
		lv0 <= 1'b0;
		lv1 <= 1'b1;
		ext_v <= 1'b1;
		settle(3);
		rd(8'h0e, 8'h7b);
		rd(8'h0e, 8'h0b);
		@(posedge clk_sys);
		lv0 <= 1'b1;
		ext_v <= 1'b0;
		settle(3);
		rd(8'h0e, 8'h0b);
		for (int j = 1; j >= 0; j--)
		begin
			wr(8'h0e, {4'h0, j[0], 3'h3});
			for (int k = 0; k < 6; k++)
			begin
				@(posedge clk_sys);
				irq_n <= 1'($urandom);
				spi_do <= 1'($urandom);
				cs_n <= 1'($urandom);
				settle(1);
				compare_bit("ser_out", (j[0] && cs_n) ? irq_n : spi_do,
					ser_out);
			end
		end
		settle(3);
		stop_test();
	end
endmodule : tb_top
